// *** src/pscf_pkg.sv ***
package pscf_pkg;
  localparam int          NMOD        = 3;
  localparam int          CW          = 12;
  localparam int          FILT_LEN    = 4;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  ICTL_OFF    = 8'h04;
  localparam logic [7:0]  SA_OFF      = 8'h10;
  localparam logic [7:0]  RA_OFF      = 8'h1c;
  localparam logic [7:0]  SB_OFF      = 8'h28;
  localparam logic [7:0]  RB_OFF      = 8'h34;
  localparam logic [7:0]  SYNC_OFF    = 8'h38;
  localparam logic [7:0]  STAT_OFF    = 8'h3c;
  // Control register fields
  localparam int          C_RUN       = 0;
  localparam int          C_CLKSEL    = 1;
  localparam int          C_PRE       = 2;
  localparam int          C_MODE      = 4;
  localparam int          C_POLA      = 5;
  localparam int          C_POLB      = 6;
  localparam int          C_OVL       = 7;
  localparam int          C_IEN_END   = 10;
  localparam int          C_IEN_FLT   = 11;
  localparam int          CTRL_W      = 12;
  // Input control register fields
  localparam int          I_MODE      = 0;
  localparam int          I_LEVEL     = 3;
  localparam int          I_FILT      = 4;
  localparam int          I_ASYA      = 5;
  localparam int          I_ASYB      = 6;
  localparam int          ICTL_W      = 7;
  // Status register: fault flags in [2:0], end-of-cycle flag at 3
  localparam int          S_END       = 3;
  localparam logic [11:0] CTRL_RST    = 12'h000;
  localparam logic [6:0]  ICTL_RST    = 7'h00;
  // Prescaler terminal counts for divide by 1, 4, 32, 256
  localparam logic [7:0]  DIV1_TC     = 8'h00;
  localparam logic [7:0]  DIV4_TC     = 8'h03;
  localparam logic [7:0]  DIV32_TC    = 8'h1f;
  localparam logic [7:0]  DIV256_TC   = 8'hff;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : pscf_pkg

// *** src/pscf_top.sv ***
`timescale 1ns/1ps
// Contract
// - With overlap protection on, outputs A and B of a module never both active.
// - Filter enable passes the fault input through a four-cycle digital filter.
// - Async control lets the raw fault input kill outputs without the PWM clock.
// - Under async control the input still runs the normal input logic.
// - Level select set means rising or high active, clear means falling or low.
// - Centered: input A acts only in phase 0, input B only in phase 1.
// - One-ramp: both inputs act over the whole ramp.
// - Input mode picks ignore, kill A, B, A and B, all outputs, or halt.
// - Kill modes suppress outputs while counter and timing run on.
// - Halt mode stops the controller until software sets the run bit.
// - Each module makes an ADC sync pulse from edges of its A or B output in one-ramp mode, from the reset-A match in centered mode if sync bit 1 is clear.
// - An input event is the active edge or the start of the active level.
// - End-of-cycle interrupt, when enabled, on a match with shared reset-B.
// - Fault interrupt, when enabled, on any input fault event; separate line.
// - Clock select picks I/O or PLL clock; prescaler divides by 1, 4, 32, 256.
// - Four 12-bit compares per module: set/reset A, set/reset B, reset-B shared.
// - Each module has its own input logic watching one fault input.
// - Mode bit picks one-ramp counting at 0, centered up/down at 1.
// - Polarity bits make outputs active low when clear, active high when set.
module pscf_top
  import pscf_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             pll_clk_en,
  input  wire logic [NMOD-1:0]  module_fault_input,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [NMOD-1:0]       module_output_a,
  output logic [NMOD-1:0]       module_output_b,
  output logic [NMOD-1:0]       adc_sync_out,
  output logic                  end_of_cycle_vector,
  output logic                  fault_event_vector
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                          awready, wready, bvalid, arready, rvalid;
    logic [1:0]                    bresp, rresp;
    logic [31:0]                   rdata;
    logic [CTRL_W-1:0]             ctrl;
    logic [NMOD-1:0][ICTL_W-1:0]   ictl;
    logic [NMOD-1:0][CW-1:0]       sa, ra, sb;
    logic [CW-1:0]                 rb;
    logic [NMOD-1:0][1:0]          sync;
    logic [3:0]                    flags;
    logic [7:0]                    pre_cnt;
    logic [CW-1:0]                 cnt;
    logic                          down;
    logic [NMOD-1:0][FILT_LEN-1:0] filt_sh;
    logic [NMOD-1:0]               filt_v, hit_prev, act_a, act_b, outa, outb, adc;
    logic                          irq_end, irq_flt;
  } pscf_state_t;

  pscf_state_t q_q, s_d;
  logic        tick, eoc, halt;
  logic [NMOD-1:0] ev;

  function automatic logic [31:0] pscf_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : pscf_merge

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0]      div_tc;
    logic [31:0]     w;
    logic            onr, ph_a, act, hit_a, hit_b, a, b, all_dis, raw_a, raw_b;
    logic [NMOD-1:0] dis_a, dis_b, asy_a, asy_b;
    logic [2:0]      md;
    logic            wok, rok;
    div_tc  = DIV1_TC;
    w       = 32'h0;
    act     = 1'b0;
    hit_a   = 1'b0;
    hit_b   = 1'b0;
    a       = 1'b0;
    b       = 1'b0;
    raw_a   = 1'b0;
    raw_b   = 1'b0;
    ph_a    = 1'b0;
    md      = 3'h0;
    all_dis = 1'b0;
    dis_a   = '0;
    dis_b   = '0;
    asy_a   = '0;
    asy_b   = '0;
    wok     = 1'b0;
    rok     = 1'b0;
    halt    = 1'b0;
    ev      = '0;
    s_d     = q_q;
    onr     = !q_q.ctrl[C_MODE];
    // Bus slave: address and data are taken together, one write and one read at a time
    s_d.awready = s_axi_awvalid && s_axi_wvalid && !q_q.awready && !q_q.bvalid;
    s_d.wready  = s_axi_awvalid && s_axi_wvalid && !q_q.awready && !q_q.bvalid;
    if (q_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
    if (q_q.awready) begin
      wok = 1'b1;
      unique case (s_axi_awaddr)
        CTRL_OFF: s_d.ctrl = CTRL_W'(pscf_merge(32'(q_q.ctrl), s_axi_wdata, s_axi_wstrb));
        RB_OFF:   s_d.rb = CW'(pscf_merge(32'(q_q.rb), s_axi_wdata, s_axi_wstrb));
        STAT_OFF: s_d.flags = q_q.flags & ~(s_axi_wdata[3:0] & {4{s_axi_wstrb[0]}});
        SYNC_OFF: s_d.sync = 6'(pscf_merge(32'(q_q.sync), s_axi_wdata, s_axi_wstrb));
        default:  wok = 1'b0;
      endcase
      for (int m = 0; m < NMOD; m++) begin
        if (s_axi_awaddr == ICTL_OFF + 8'(4*m)) begin
          wok = 1'b1;
          s_d.ictl[m] = ICTL_W'(pscf_merge(32'(q_q.ictl[m]), s_axi_wdata, s_axi_wstrb));
        end
        if (s_axi_awaddr == SA_OFF + 8'(4*m)) begin
          wok = 1'b1;
          s_d.sa[m] = CW'(pscf_merge(32'(q_q.sa[m]), s_axi_wdata, s_axi_wstrb));
        end
        if (s_axi_awaddr == RA_OFF + 8'(4*m)) begin
          wok = 1'b1;
          s_d.ra[m] = CW'(pscf_merge(32'(q_q.ra[m]), s_axi_wdata, s_axi_wstrb));
        end
        if (s_axi_awaddr == SB_OFF + 8'(4*m)) begin
          wok = 1'b1;
          s_d.sb[m] = CW'(pscf_merge(32'(q_q.sb[m]), s_axi_wdata, s_axi_wstrb));
        end
      end
      s_d.bvalid = 1'b1;
      s_d.bresp  = wok ? RESP_OK : RESP_SLVERR;
    end
    s_d.arready = s_axi_arvalid && !q_q.arready && !q_q.rvalid;
    if (q_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    if (q_q.arready) begin
      rok = 1'b1;
      unique case (s_axi_araddr)
        CTRL_OFF: w = 32'(q_q.ctrl);
        RB_OFF:   w = 32'(q_q.rb);
        STAT_OFF: w = {27'h0, q_q.ctrl[C_RUN], q_q.flags};
        SYNC_OFF: w = 32'(q_q.sync);
        default:  rok = 1'b0;
      endcase
      for (int m = 0; m < NMOD; m++) begin
        if (s_axi_araddr == ICTL_OFF + 8'(4*m)) begin rok = 1'b1; w = 32'(q_q.ictl[m]); end
        if (s_axi_araddr == SA_OFF + 8'(4*m))   begin rok = 1'b1; w = 32'(q_q.sa[m]);   end
        if (s_axi_araddr == RA_OFF + 8'(4*m))   begin rok = 1'b1; w = 32'(q_q.ra[m]);   end
        if (s_axi_araddr == SB_OFF + 8'(4*m))   begin rok = 1'b1; w = 32'(q_q.sb[m]);   end
      end
      s_d.rvalid = 1'b1;
      s_d.rdata  = w;
      s_d.rresp  = rok ? RESP_OK : RESP_SLVERR;
    end

    // ****************************************
    // Clock select and prescaler
    // ****************************************
    unique case (q_q.ctrl[C_PRE +: 2])
      2'h0: div_tc = DIV1_TC;
      2'h1: div_tc = DIV4_TC;
      2'h2: div_tc = DIV32_TC;
      2'h3: div_tc = DIV256_TC;
    endcase
    tick = 1'b0;
    if (q_q.ctrl[C_RUN] && (!q_q.ctrl[C_CLKSEL] || pll_clk_en)) begin
      if (q_q.pre_cnt >= div_tc) begin
        s_d.pre_cnt = 8'h00;
        tick        = 1'b1;
      end else begin
        s_d.pre_cnt = q_q.pre_cnt + 8'h01;
      end
    end
    eoc = tick && (q_q.cnt == q_q.rb);

    // ****************************************
    // Counter: fault kill modes never touch it
    // ****************************************
    if (tick) begin
      if (onr) begin
        s_d.down = 1'b0;
        s_d.cnt  = eoc ? '0 : q_q.cnt + CW'(1);
      end else if (!q_q.down) begin
        if (q_q.cnt >= q_q.rb) begin
          s_d.down = 1'b1;
          s_d.cnt  = (q_q.cnt == '0) ? '0 : q_q.cnt - CW'(1);
        end else begin
          s_d.cnt  = q_q.cnt + CW'(1);
        end
      end else if (q_q.cnt == '0) begin
        s_d.down = 1'b0;
        s_d.cnt  = (q_q.rb == '0) ? '0 : CW'(1);
      end else begin
        s_d.cnt  = q_q.cnt - CW'(1);
      end
    end

    // ****************************************
    // Fault inputs, one per module
    // ****************************************
    for (int m = 0; m < NMOD; m++) begin
      md = q_q.ictl[m][I_MODE +: 3];
      if (tick) begin
        s_d.filt_sh[m] = {q_q.filt_sh[m][FILT_LEN-2:0], module_fault_input[m]};
        if (&s_d.filt_sh[m]) s_d.filt_v[m] = 1'b1;
        if (~|s_d.filt_sh[m]) s_d.filt_v[m] = 1'b0;
      end
      act = (q_q.ictl[m][I_FILT] ? q_q.filt_v[m] : module_fault_input[m])
            ^ !q_q.ictl[m][I_LEVEL];
      ph_a  = onr ? (q_q.cnt < q_q.ra[m]) : (q_q.cnt < q_q.sa[m]);
      hit_a = act && (onr || ph_a);
      hit_b = act && (onr || !ph_a);
      if (tick) s_d.hit_prev[m] = hit_a || hit_b;
      ev[m] = tick && (hit_a || hit_b) && !q_q.hit_prev[m] && (md != 3'h0);
      dis_a[m] = hit_a && (md == 3'h1 || md == 3'h3);
      dis_b[m] = hit_b && (md == 3'h2 || md == 3'h3);
      if (md[2] && !md[1] && (hit_a || hit_b)) all_dis = 1'b1;
      if (md[2] && md[1] && ev[m]) halt = 1'b1;
      // Raw pin path works even when the divided clock is stalled
      asy_a[m] = q_q.ictl[m][I_ASYA] && (module_fault_input[m] ^ !q_q.ictl[m][I_LEVEL]);
      asy_b[m] = q_q.ictl[m][I_ASYB] && (module_fault_input[m] ^ !q_q.ictl[m][I_LEVEL]);
    end
    // Halt beats a run-bit write in the same cycle so a fault is never missed
    if (halt) s_d.ctrl[C_RUN] = 1'b0;
    s_d.flags[NMOD-1:0] = s_d.flags[NMOD-1:0] | ev;
    if (eoc) s_d.flags[S_END] = 1'b1;
    s_d.irq_end = q_q.ctrl[C_IEN_END] && q_q.flags[S_END];
    s_d.irq_flt = q_q.ctrl[C_IEN_FLT] && (|q_q.flags[NMOD-1:0]);

    // ****************************************
    // Waveforms, overlap, polarity, ADC sync
    // ****************************************
    for (int m = 0; m < NMOD; m++) begin
      raw_a = onr ? (q_q.cnt >= q_q.sa[m] && q_q.cnt < q_q.ra[m]) : (q_q.cnt < q_q.sa[m]);
      raw_b = onr ? (q_q.cnt >= q_q.sb[m] && q_q.cnt < q_q.rb) : (q_q.cnt >= q_q.sb[m]);
      a = q_q.ctrl[C_RUN] && raw_a && !dis_a[m] && !all_dis && !asy_a[m];
      b = q_q.ctrl[C_RUN] && raw_b && !dis_b[m] && !all_dis && !asy_b[m];
      if (q_q.ctrl[C_OVL + m] && a) b = 1'b0;
      s_d.act_a[m] = a;
      s_d.act_b[m] = b;
      s_d.outa[m]  = q_q.ctrl[C_POLA] ? a : !a;
      s_d.outb[m]  = q_q.ctrl[C_POLB] ? b : !b;
      if (onr) begin
        unique case (q_q.sync[m])
          2'h0: s_d.adc[m] = a && !q_q.act_a[m];
          2'h1: s_d.adc[m] = !a && q_q.act_a[m];
          2'h2: s_d.adc[m] = b && !q_q.act_b[m];
          2'h3: s_d.adc[m] = !b && q_q.act_b[m];
        endcase
      end else begin
        s_d.adc[m] = tick && !q_q.sync[m][1] && (q_q.cnt == q_q.ra[m])
                     && (q_q.down != q_q.sync[m][0]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_q      <= '0;
      q_q.ctrl <= CTRL_RST;
      q_q.ictl <= {NMOD{ICTL_RST}};
      q_q.outa <= '1;
      q_q.outb <= '1;
    end else begin
      q_q <= s_d;
    end
  end

  assign s_axi_awready       = q_q.awready;
  assign s_axi_wready        = q_q.wready;
  assign s_axi_bvalid        = q_q.bvalid;
  assign s_axi_bresp         = q_q.bresp;
  assign s_axi_arready       = q_q.arready;
  assign s_axi_rvalid        = q_q.rvalid;
  assign s_axi_rdata         = q_q.rdata;
  assign s_axi_rresp         = q_q.rresp;
  assign module_output_a     = q_q.outa;
  assign module_output_b     = q_q.outb;
  assign adc_sync_out        = q_q.adc;
  assign end_of_cycle_vector = q_q.irq_end;
  assign fault_event_vector  = q_q.irq_flt;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_OVERLAP: assert property (q_q.ctrl[C_OVL] |=> !(q_q.act_a[0] && q_q.act_b[0]))
    else $error("module 0 outputs overlap");
  AST_FILTER: assert property ($rose(q_q.filt_v[0]) |-> q_q.filt_sh[0] == 4'hf)
    else $error("filter passed a level seen fewer than four ticks");
  AST_ASYNC: assert property (q_q.ictl[0][I_ASYA]
      && (module_fault_input[0] ^ !q_q.ictl[0][I_LEVEL]) |=> !q_q.act_a[0])
    else $error("async kill failed on output A");
  AST_HALT: assert property (halt |=> !q_q.ctrl[C_RUN] ##1 (q_q.cnt == $past(q_q.cnt)))
    else $error("halt did not stop the counter");
  AST_DIV: assert property (tick && q_q.ctrl[C_PRE +: 2] == 2'h1 && !q_q.ctrl[C_CLKSEL]
      |=> !tick [*3])
    else $error("divide by four ticked early");
  AST_EOC: assert property (eoc && q_q.ctrl[C_IEN_END] && !s_axi_awready
      |-> ##2 end_of_cycle_vector)
    else $error("end of cycle interrupt missing");
  AST_FLT: assert property ((|ev) && q_q.ctrl[C_IEN_FLT] && !s_axi_awready
      |-> ##2 fault_event_vector)
    else $error("fault interrupt missing");
  AST_POL: assert property (!q_q.ctrl[C_RUN]
      |=> module_output_a == {NMOD{!$past(q_q.ctrl[C_POLA])}})
    else $error("stopped output A not inactive");
  AST_IGNORE: assert property (q_q.ictl[0][I_MODE +: 3] == 3'h0 |=> !$rose(q_q.flags[0]))
    else $error("ignored input raised an event");
endmodule : pscf_top

// *** verification/pscf_fault_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Fault sensor model: commanded trip level with selectable lag
// ************************************************************
module pscf_fault_model (
  input  wire logic       clk,
  input  wire logic [2:0] drive_active,
  input  wire logic [3:0] lag,
  output logic      [2:0] module_fault_input
);
  logic [2:0] hist_q [16];
  initial begin
    foreach (hist_q[i]) hist_q[i] = 3'h0;
  end
  always @(posedge clk) begin
    hist_q[0] <= drive_active;
    for (int i = 1; i < 16; i++)
      hist_q[i] <= hist_q[i-1];
  end
  // Lag models a slow trip path, so late faults are exercised as well
  assign module_fault_input = hist_q[lag];
endmodule : pscf_fault_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
// ************************************************************
// Bench: register tasks and sequenced checks
// ************************************************************
module tb_top;
  import pscf_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, pll_clk_en = 1'b0;
  logic [2:0]  drv = 3'h0, fin, oa, ob, adc;
  logic [3:0]  lag = 4'h0, wstrb = 4'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, eoc, fev;
  logic [1:0]  bresp, rresp, rs, bs;
  int          err_count = 0, num_checks = 0, a0, b0, a1, bo, ad;
  int          ps [5] = '{0, 4, 8, 12, 2};
  int          mul [5] = '{1, 4, 32, 256, 2};
  int          ic [7] = '{9, 10, 11, 12, 40, 3, 8};
  int          inp [7] = '{1, 1, 1, 1, 1, 0, 1};
  int          ea0 [7] = '{0, 6, 0, 0, 0, 0, 6};
  int          eb0 [7] = '{6, 0, 0, 0, 6, 0, 6};
  int          ea1 [7] = '{6, 6, 6, 0, 6, 6, 6};

  always #25 clk = ~clk;
  always @(posedge clk) pll_clk_en <= ~pll_clk_en;

  pscf_top i_dut (
    .clk(clk), .reset(reset), .pll_clk_en(pll_clk_en), .module_fault_input(fin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_output_a(oa), .module_output_b(ob), .adc_sync_out(adc),
    .end_of_cycle_vector(eoc), .fault_event_vector(fev)
  );
  pscf_fault_model i_flt (.clk(clk), .drive_active(drv), .lag(lag), .module_fault_input(fin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0, w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_t(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_t

  task automatic cnt(input int n);
    a0 = 0; b0 = 0; a1 = 0; bo = 0; ad = 0;
    repeat (n) begin
      @(posedge clk);
      a0 += int'(oa[0] === 1'b1);
      b0 += int'(ob[0] === 1'b1);
      a1 += int'(oa[1] === 1'b1);
      bo += int'(oa[0] === 1'b1 && ob[0] === 1'b1);
      ad += int'(adc[0] === 1'b1);
    end
  endtask : cnt

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(oa, 3'h7);
    chk(ob, 3'h7);
    rd_t(8'h40);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    rd_t(CTRL_OFF);
    chk(rd, 32'h0);
    wr(8'h40, 32'h1);
    chk(bs, RESP_SLVERR);
    for (int m = 0; m < 3; m++) begin
      wr(SA_OFF + 8'(4 * m), 32'h2);
      wr(RA_OFF + 8'(4 * m), 32'h5);
      wr(SB_OFF + 8'(4 * m), 32'h7);
    end
    wr(RB_OFF, 32'ha);
    chk(bs, RESP_OK);
    // Period is 11 ticks; A active 3 ticks and B active 3 ticks per period
    foreach (ps[i]) begin
      wr(CTRL_OFF, 32'h61 | ps[i]);
      repeat (11 * mul[i]) @(posedge clk);
      cnt(22 * mul[i]);
      chk(a0, 6 * mul[i]);
      chk(b0, 6 * mul[i]);
    end
    wr(CTRL_OFF, 32'h61);
    repeat (22) @(posedge clk);
    chk(eoc, 1'b0);
    wr(CTRL_OFF, 32'h461);
    repeat (3) @(posedge clk);
    chk(eoc, 1'b1);
    rd_t(STAT_OFF);
    chk(rd[S_END], 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(SYNC_OFF, 32'(s));
      repeat (11) @(posedge clk);
      cnt(22);
      chk(ad, 2);
    end
    wr(CTRL_OFF, 32'h61);
    foreach (ic[i]) begin
      drv <= 3'(inp[i]);
      wr(ICTL_OFF, 32'(ic[i]));
      repeat (8) @(posedge clk);
      cnt(22);
      chk(a0, ea0[i]);
      chk(b0, eb0[i]);
      chk(a1, ea1[i]);
    end
    drv <= 3'h0;
    wr(ICTL_OFF, 32'h0);
    wr(SB_OFF, 32'h3);
    repeat (11) @(posedge clk);
    cnt(22);
    chk(bo, 4);
    wr(CTRL_OFF, 32'he1);
    repeat (11) @(posedge clk);
    cnt(22);
    chk(bo, 0);
    chk(a0, 6);
    chk(b0, 10);
    wr(SB_OFF, 32'h7);
    wr(CTRL_OFF, 32'h61);
    // Filter only tried with the undivided clock, where its delay is short
    wr(STAT_OFF, 32'hf);
    wr(ICTL_OFF, 32'h1b);
    drv <= 3'h1;
    repeat (2) @(posedge clk);
    drv <= 3'h0;
    repeat (6) @(posedge clk);
    rd_t(STAT_OFF);
    chk(rd[0], 1'b0);
    drv <= 3'h1;
    repeat (8) @(posedge clk);
    drv <= 3'h0;
    repeat (4) @(posedge clk);
    rd_t(STAT_OFF);
    chk(rd[0], 1'b1);
    chk(fev, 1'b0);
    wr(STAT_OFF, 32'hf);
    wr(ICTL_OFF, 32'he);
    wr(CTRL_OFF, 32'h861);
    lag <= 4'h5;
    drv <= 3'h1;
    repeat (12) @(posedge clk);
    rd_t(STAT_OFF);
    chk(rd[4], 1'b0);
    chk(rd[0], 1'b1);
    chk(fev, 1'b1);
    chk(eoc, 1'b0);
    chk(oa, 3'h0);
    chk(ob, 3'h0);
    drv <= 3'h0;
    lag <= 4'h0;
    repeat (8) @(posedge clk);
    wr(CTRL_OFF, 32'h861);
    repeat (3) @(posedge clk);
    rd_t(STAT_OFF);
    chk(rd[4], 1'b1);
    // Centered counting: reset-A times the ADC pulse, so it is kept at 1 or more
    wr(ICTL_OFF, 32'h0);
    wr(RA_OFF, 32'h5);
    wr(CTRL_OFF, 32'h71);
    for (int s = 0; s < 4; s++) begin
      wr(SYNC_OFF, 32'(s));
      repeat (22) @(posedge clk);
      cnt(44);
      if (s < 2) chk(32'(ad >= 2 && ad <= 3), 32'h1);
      else chk(ad, 32'h0);
    end
    wrap_up();
  end
endmodule : tb_top
